// >>> core/epcl_pkg.sv
// Constants, field layout and state types of the port configuration loader
package epcl_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int             NUM_PORTS   = 3;
    localparam int             NUM_WORDS   = 5;

    // Configuration memory word addresses
    localparam logic [7:0]     EE_SIG_ADDR = 8'h00;
    localparam logic [7:0]     EE_SLOT0    = 8'h60;
    localparam logic [7:0]     EE_SLOT1    = 8'h62;
    localparam logic [7:0]     EE_SLOT2    = 8'h64;
    localparam logic [7:0]     EE_TL0      = 8'h68;
    localparam logic [7:0]     EE_TL1      = 8'h6A;
    localparam logic [2:0]     LAST_WORD   = 3'h4;

    // Field defaults per port, index is the port
    localparam logic [2:0][15:0] SLOT_DEF  = {16'h0022, 16'h0012, 16'h0002};
    localparam logic [2:0][15:0] TL_DEF    = {16'h0370, 16'h0370, 16'h0376};

    ////////////////////////////////////////////////////////////////////////
    // Slot configuration word layout
    localparam int             SW_SLOT_IMPL = 0;
    localparam int             SW_CONN_CLK  = 1;
    localparam int             SW_DSI       = 2;
    localparam int             SW_LPVC      = 3;
    localparam int             SW_PNUM_LO   = 4;
    localparam int             SW_PNUM_HI   = 6;
    localparam int             SW_TCMAP_LO  = 9;
    localparam int             SW_TCMAP_HI  = 15;
    localparam logic [15:0]    SW_USED      = 16'hFE7F;
    localparam logic [15:0]    SW_WRITABLE  = 16'hFE7C;

    // Transaction-layer control word layout
    localparam int             TW_DISABLE   = 0;
    localparam int             TW_RST_SEL   = 1;
    localparam int             TW_CLK_PM    = 2;
    localparam int             TW_PCIPM     = 4;
    localparam int             TW_ASPM      = 5;
    localparam int             TW_L1SS      = 6;
    localparam int             TW_ARB       = 8;
    localparam int             TW_GNT_FAIL  = 9;
    localparam logic [15:0]    TW_USED      = 16'h0377;

    ////////////////////////////////////////////////////////////////////////
    // Register word indices on the bus (byte address is four times)
    localparam logic [3:0]     REG_CTRL     = 4'h0;
    localparam logic [3:0]     REG_STATUS   = 4'h1;
    localparam logic [3:0]     REG_SLOT_P0  = 4'h4;
    localparam logic [3:0]     REG_TL_P0    = 4'h8;
    localparam int             CTRL_RELOAD  = 0;
    localparam int             STAT_DONE    = 0;
    localparam int             STAT_VALID   = 1;
    localparam int             STAT_CNT_LO  = 4;

    // Serial memory framing
    localparam logic [7:0]     CMD_READ     = 8'h03;
    localparam logic [4:0]     FRAME_LAST   = 5'h1F;
    localparam logic [4:0]     RX_FIRST     = 5'h10;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SIG   = 2'b01,
        ST_WORDS = 2'b11,
        ST_DONE  = 2'b10
    } epcl_state_t;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_SHIFT = 2'b01,
        RD_DONE  = 2'b11
    } epcl_rd_state_t;

endpackage

// >>> core/epcl_rd_if.sv
// Word fetch channel between the loader and the serial memory reader
`timescale 1ns/100ps
interface epcl_rd_if;
    logic        req;
    logic [7:0]  addr;
    logic        ack;
    logic [15:0] data;

    modport master (output req, output addr, input ack, input data);
    modport reader (input req, input addr, output ack, output data);
endinterface

// >>> core/epcl_ee_reader.sv
// Serial memory word reader: one 16-bit word per framed read command
`timescale 1ns/100ps
module epcl_ee_reader #(
    parameter int SCK_HALF = 4
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    epcl_rd_if.reader rd,
    output logic      ee_sck,
    output logic      ee_cs_n,
    output logic      ee_mosi,
    input  wire logic ee_miso
);

    ////////////////////////////////////////////////////////////////////////
    // Two stages of sync leave miso valid only if a half period is >= 3
    if (SCK_HALF < 3 || SCK_HALF > 255) begin : g_bad_half
        $error("SCK_HALF must lie in 3..255");
    end

    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

    epcl_pkg::epcl_rd_state_t state;
    logic [7:0]               cnt;
    logic [4:0]               bitn;
    logic [31:0]              tx;
    logic [15:0]              rx;
    logic                     miso_meta;
    logic                     miso_sync;
    logic                     ack_q;
    logic [15:0]              data_q;

    wire half_tick = (cnt == HALF_LAST);
    wire rising    = half_tick & ~ee_sck;
    wire falling   = half_tick & ee_sck;
    wire last_bit  = (bitn == epcl_pkg::FRAME_LAST);

    assign rd.ack  = ack_q;
    assign rd.data = data_q;
    assign ee_mosi = tx[31];

    always_ff @(posedge sys_clk) begin
        miso_meta <= ee_miso;
        miso_sync <= miso_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state   <= epcl_pkg::RD_IDLE;
            cnt     <= 8'h00;
            bitn    <= 5'h00;
            tx      <= 32'h0000_0000;
            rx      <= 16'h0000;
            ee_sck  <= 1'b0;
            ee_cs_n <= 1'b1;
            ack_q   <= 1'b0;
            data_q  <= 16'h0000;
        end else begin
            case (state)
                epcl_pkg::RD_IDLE: begin
                    if (rd.req) begin
                        tx      <= {epcl_pkg::CMD_READ, rd.addr, 16'h0000};
                        ee_cs_n <= 1'b0;
                        bitn    <= 5'h00;
                        cnt     <= 8'h00;
                        state   <= epcl_pkg::RD_SHIFT;
                    end
                end
                epcl_pkg::RD_SHIFT: begin
                    cnt <= half_tick ? 8'h00 : cnt + 8'h01;
                    if (half_tick) begin
                        ee_sck <= ~ee_sck;
                    end
                    if (rising && bitn >= epcl_pkg::RX_FIRST) begin
                        rx <= {rx[14:0], miso_sync};
                    end
                    if (falling && last_bit) begin
                        ee_cs_n <= 1'b1;
                        ack_q   <= 1'b1;
                        data_q  <= rx;
                        state   <= epcl_pkg::RD_DONE;
                    end else if (falling) begin
                        bitn <= bitn + 5'h01;
                        tx   <= {tx[30:0], 1'b0};
                    end
                end
                default: begin
                    ack_q <= 1'b0;
                    state <= epcl_pkg::RD_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> core/epcl_loader.sv
// Power-up port configuration loader with Avalon-MM register access
// Summary of operation
// - Word 62h bit0 sets port1 slot implemented
// - Slot word bit1 sets connector clock bit
// - Slot word bit2 sets device-specific init bit
// - Slot word bit3 sets VC1 low-priority allocation
// - Slot word bits 6:4 give logical port
// - Slot word bits 15:9 give TC/VC0 map
// - Word 64h is port2 slot word, default 22h
// - Slot implemented and clock bits ignore software
// - Word 68h: port0 disable, reset select, 0376h
// - Control word bit2 gives clock PM capability
// - Control bits 4,5,6 give L1 substate supports
// - Control bits 8,9 give arbitration modes
// - Word 6Ah is port1 control word, 0370h
// - Word 60h is port0 slot word, 02h
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module epcl_loader #(
    parameter logic [15:0] SIGNATURE = 16'h5A3C,
    parameter int          SCK_HALF  = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             ee_sck,
    output logic             ee_cs_n,
    output logic             ee_mosi,
    input  wire logic        ee_miso,
    output logic             cfg_ready,
    output logic      [2:0]  slot_implemented,
    output logic      [2:0]  connector_clock,
    output logic      [2:0]  dsi_required,
    output logic      [2:0]  lpvc_vc1,
    output logic      [8:0]  logical_port_num,
    output logic      [20:0] tc_vc0_map,
    output logic      [2:0]  port_disable,
    output logic      [2:0]  reset_pin_sel,
    output logic      [2:0]  clock_pm_cap,
    output logic      [2:0]  pcipm_l1_1_support,
    output logic      [2:0]  aspm_l1_1_support,
    output logic      [2:0]  l1_substates_support,
    output logic      [2:0]  vc_arbitration_mode,
    output logic      [2:0]  grant_fail_mode
);

    ////////////////////////////////////////////////////////////////////////
    if (SCK_HALF < 3) begin : g_bad_half
        $error("SCK_HALF below 3 cannot be sampled through the sync");
    end

    function automatic logic [7:0] word_addr(input logic [2:0] idx);
        case (idx)
            3'h0:    word_addr = epcl_pkg::EE_SLOT0;
            3'h1:    word_addr = epcl_pkg::EE_SLOT1;
            3'h2:    word_addr = epcl_pkg::EE_SLOT2;
            3'h3:    word_addr = epcl_pkg::EE_TL0;
            default: word_addr = epcl_pkg::EE_TL1;
        endcase
    endfunction

    epcl_rd_if rd_bus ();

    epcl_ee_reader #(
        .SCK_HALF (SCK_HALF)
    ) u_reader (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .rd      (rd_bus.reader),
        .ee_sck  (ee_sck),
        .ee_cs_n (ee_cs_n),
        .ee_mosi (ee_mosi),
        .ee_miso (ee_miso)
    );

    ////////////////////////////////////////////////////////////////////////
    epcl_pkg::epcl_state_t state;
    epcl_pkg::epcl_state_t next_state;
    logic [2:0]            word_idx;
    logic                  mem_valid;
    logic [3:0]            words_loaded;
    logic                  rd_req;
    logic [15:0]           slot_word [0:2];
    logic [15:0]           tl_word   [0:2];

    wire        got_word  = rd_bus.ack;
    wire        sig_ok    = (rd_bus.data == SIGNATURE);
    wire        last_word = (word_idx == epcl_pkg::LAST_WORD);

    assign rd_bus.req  = rd_req;
    assign rd_bus.addr = (state == epcl_pkg::ST_SIG) ?
                         epcl_pkg::EE_SIG_ADDR : word_addr(word_idx);

    // Bus decode
    wire        bus_req   = avs_read | avs_write;
    wire        bus_take  = bus_req & ~avs_waitrequest;
    wire        bus_wr    = avs_write & bus_take;
    wire [3:0]  slot_off  = avs_address - epcl_pkg::REG_SLOT_P0;
    wire [3:0]  tl_off    = avs_address - epcl_pkg::REG_TL_P0;
    wire        is_slot   = (avs_address >= epcl_pkg::REG_SLOT_P0) &&
                            (slot_off < 4'(epcl_pkg::NUM_PORTS));
    wire        is_tl     = (avs_address >= epcl_pkg::REG_TL_P0) &&
                            (tl_off < 4'(epcl_pkg::NUM_PORTS));
    wire [1:0]  slot_p    = slot_off[1:0];
    wire [1:0]  tl_p      = tl_off[1:0];
    wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        reload    = bus_wr && (avs_address == epcl_pkg::REG_CTRL) &&
                            avs_byteenable[0] &&
                            avs_writedata[epcl_pkg::CTRL_RELOAD];
    wire [15:0] slot_wmask = lane_mask & epcl_pkg::SW_WRITABLE;
    wire [15:0] tl_wmask   = lane_mask & epcl_pkg::TW_USED;

    logic [31:0] read_value;

    always_comb begin
        read_value = 32'h0000_0000;
        if (avs_address == epcl_pkg::REG_STATUS) begin
            read_value[epcl_pkg::STAT_DONE]  = cfg_ready;
            read_value[epcl_pkg::STAT_VALID] = mem_valid;
            read_value[epcl_pkg::STAT_CNT_LO +: 4] = words_loaded;
        end else if (is_slot) begin
            read_value[15:0] = slot_word[slot_p] & epcl_pkg::SW_USED;
        end else if (is_tl) begin
            read_value[15:0] = tl_word[tl_p] & epcl_pkg::TW_USED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load sequence: signature check, then the five words in order
    always_comb begin
        next_state = state;
        case (state)
            epcl_pkg::ST_IDLE: begin
                next_state = epcl_pkg::ST_SIG;
            end
            epcl_pkg::ST_SIG: begin
                if (got_word) begin
                    // Blank or foreign memory ends the load at once
                    next_state = sig_ok ? epcl_pkg::ST_WORDS
                                        : epcl_pkg::ST_DONE;
                end
            end
            epcl_pkg::ST_WORDS: begin
                if (got_word && last_word) begin
                    next_state = epcl_pkg::ST_DONE;
                end
            end
            default: begin
                if (reload) begin
                    next_state = epcl_pkg::ST_SIG;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state        <= epcl_pkg::ST_IDLE;
            word_idx     <= 3'h0;
            mem_valid    <= 1'b0;
            words_loaded <= 4'h0;
            rd_req       <= 1'b0;
            cfg_ready    <= 1'b0;
        end else begin
            state     <= next_state;
            cfg_ready <= (next_state == epcl_pkg::ST_DONE);
            // Request drops for one cycle after each word so the reader
            // cannot mistake a stale request for a new fetch
            rd_req    <= (next_state == epcl_pkg::ST_SIG ||
                          next_state == epcl_pkg::ST_WORDS) && !got_word;
            if (state == epcl_pkg::ST_SIG && got_word) begin
                mem_valid    <= sig_ok;
                word_idx     <= 3'h0;
                words_loaded <= 4'h0;
            end else if (state == epcl_pkg::ST_WORDS && got_word) begin
                word_idx     <= word_idx + 3'h1;
                words_loaded <= words_loaded + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field storage; software reaches it only once loading is over
    wire apply = (state == epcl_pkg::ST_WORDS) && got_word;

    for (genvar p = 0; p < epcl_pkg::NUM_PORTS; p++) begin : g_port
        localparam logic [2:0] SLOT_IDX = 3'(p);
        localparam logic [2:0] TL_IDX   = 3'(p + 3);

        always_ff @(posedge sys_clk) begin
            if (!nrst) begin
                slot_word[p] <= epcl_pkg::SLOT_DEF[p];
                tl_word[p]   <= epcl_pkg::TL_DEF[p];
            end else if (apply && word_idx == SLOT_IDX) begin
                // Whole word in one edge
                slot_word[p] <= rd_bus.data;
            end else if (apply && word_idx == TL_IDX) begin
                tl_word[p]   <= rd_bus.data;
            end else if (bus_wr && is_slot && slot_p == 2'(p)) begin
                slot_word[p] <= (slot_word[p] & ~slot_wmask) |
                                (avs_writedata[15:0] & slot_wmask);
            end else if (bus_wr && is_tl && tl_p == 2'(p)) begin
                tl_word[p]   <= (tl_word[p] & ~tl_wmask) |
                                (avs_writedata[15:0] & tl_wmask);
            end
        end

        assign slot_implemented[p] =
            slot_word[p][epcl_pkg::SW_SLOT_IMPL];
        assign connector_clock[p] =
            slot_word[p][epcl_pkg::SW_CONN_CLK];
        assign dsi_required[p] =
            slot_word[p][epcl_pkg::SW_DSI];
        assign lpvc_vc1[p] =
            slot_word[p][epcl_pkg::SW_LPVC];
        assign logical_port_num[p*3 +: 3] =
            slot_word[p][epcl_pkg::SW_PNUM_HI:epcl_pkg::SW_PNUM_LO];
        assign tc_vc0_map[p*7 +: 7] =
            slot_word[p][epcl_pkg::SW_TCMAP_HI:epcl_pkg::SW_TCMAP_LO];
        assign port_disable[p] =
            tl_word[p][epcl_pkg::TW_DISABLE];
        assign reset_pin_sel[p] =
            tl_word[p][epcl_pkg::TW_RST_SEL];
        assign clock_pm_cap[p] =
            tl_word[p][epcl_pkg::TW_CLK_PM];
        assign pcipm_l1_1_support[p] =
            tl_word[p][epcl_pkg::TW_PCIPM];
        assign aspm_l1_1_support[p] =
            tl_word[p][epcl_pkg::TW_ASPM];
        assign l1_substates_support[p] =
            tl_word[p][epcl_pkg::TW_L1SS];
        assign vc_arbitration_mode[p] =
            tl_word[p][epcl_pkg::TW_ARB];
        assign grant_fail_mode[p] =
            tl_word[p][epcl_pkg::TW_GNT_FAIL];
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: answers one cycle after the request is seen, and only
    // once the load is complete, so no request meets half-loaded fields
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest & cfg_ready);
            if (bus_req & avs_waitrequest & cfg_ready) begin
                avs_readdata <= read_value;
            end
        end
    end

endmodule

// >>> test/epcl_checker_properties.sv
// Assertion checker for the port configuration loader
`timescale 1ns/100ps
module epcl_checker #(
    parameter int SCK_HALF = 4
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        ee_cs_n,
    input wire logic        cfg_ready,
    input wire logic [2:0]  slot_implemented,
    input wire logic [2:0]  connector_clock,
    input wire logic [2:0]  dsi_required,
    input wire logic [2:0]  lpvc_vc1,
    input wire logic [8:0]  logical_port_num,
    input wire logic [20:0] tc_vc0_map,
    input wire logic [2:0]  reset_pin_sel,
    input wire logic [2:0]  clock_pm_cap,
    input wire logic [2:0]  pcipm_l1_1_support,
    input wire logic [2:0]  aspm_l1_1_support,
    input wire logic [2:0]  l1_substates_support,
    input wire logic [2:0]  vc_arbitration_mode,
    input wire logic [2:0]  grant_fail_mode
);
    ////////////////////////////////////////
    // Six framed reads plus generous select gaps
    localparam int LOAD_MAX = 6 * (64 * SCK_HALF + 32) + 64;
    int          wait_cnt;
    logic [31:0] wd_q;
    logic        acc_wr;
    assign acc_wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    always_ff @(posedge sys_clk) begin
        wd_q <= avs_writedata;
        if (!nrst || cfg_ready) wait_cnt <= 0;
        else wait_cnt <= wait_cnt + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    property p_reset_dflt;
        $rose(nrst) |-> avs_waitrequest && !cfg_ready && ee_cs_n
            && slot_implemented == 3'h0 && connector_clock == 3'h7
            && logical_port_num == 9'h088 && reset_pin_sel == 3'h1;
    endproperty
    a_reset_dflt: assert property (p_reset_dflt)
        else $error("field not at default after reset");
    property p_stall_load;
        !cfg_ready |-> avs_waitrequest;
    endproperty
    a_stall_load: assert property (p_stall_load)
        else $error("bus answered while loading");
    property p_load_bound;
        wait_cnt < LOAD_MAX;
    endproperty
    a_load_bound: assert property (p_load_bound)
        else $error("load did not complete in time");
    property p_read_answer;
        (avs_read || avs_write) && avs_waitrequest && cfg_ready
            |=> !avs_waitrequest;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("request not answered after load");
    // A field moving mid-frame means a partial word leaked
    property p_whole_word;
        $changed(tc_vc0_map) || $changed(logical_port_num)
            || $changed(vc_arbitration_mode) |-> ##[0:2] ee_cs_n;
    endproperty
    a_whole_word: assert property (p_whole_word)
        else $error("field changed inside a memory frame");
    property p_hwinit;
        avs_write && !avs_waitrequest && avs_address inside {4'h4, 4'h5, 4'h6}
            |=> $stable(slot_implemented) && $stable(connector_clock);
    endproperty
    a_hwinit: assert property (p_hwinit)
        else $error("software changed a hardware-initialised bit");
    property p_slot_fields;
        acc_wr && avs_address == 4'h5 |=> logical_port_num[5:3] == wd_q[6:4]
            && tc_vc0_map[13:7] == wd_q[15:9];
    endproperty
    a_slot_fields: assert property (p_slot_fields)
        else $error("port 1 slot fields wrong after write");
    property p_slot_flags;
        acc_wr && avs_address == 4'h6 |=> dsi_required[2] == wd_q[2]
            && lpvc_vc1[2] == wd_q[3];
    endproperty
    a_slot_flags: assert property (p_slot_flags)
        else $error("port 2 slot flags wrong after write");
    property p_ctrl_fields;
        acc_wr && avs_address == 4'h9 |=> clock_pm_cap[1] == wd_q[2]
            && pcipm_l1_1_support[1] == wd_q[4]
            && aspm_l1_1_support[1] == wd_q[5]
            && l1_substates_support[1] == wd_q[6]
            && vc_arbitration_mode[1] == wd_q[8]
            && grant_fail_mode[1] == wd_q[9];
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("port 1 control fields wrong after write");
endmodule

bind epcl_loader epcl_checker #(.SCK_HALF(SCK_HALF)) epcl_checker_inst (.*);

// >>> test/epcl_ee_model.sv
// Behavioural serial configuration memory answering framed word reads
`timescale 1ns/100ps
module epcl_ee_model (
    input wire logic ee_sck,
    input wire logic ee_cs_n,
    input wire logic ee_mosi,
    output logic     ee_miso
);
    ////////////////////////////////////////
    logic [15:0] mem [0:255];
    logic [15:0] hdr;
    logic [15:0] word;
    int          bits;
    initial ee_miso = 1'b0;
    always @(negedge ee_cs_n) bits = 0;
    // Header bits arrive on rising clock, MSB first
    always @(posedge ee_sck) begin
        if (!ee_cs_n) begin
            if (bits < 16) hdr = {hdr[14:0], ee_mosi};
            bits = bits + 1;
            // A wrong command gets a pattern, never a real word
            if (bits == 16) word = (hdr[15:8] == 8'h03) ? mem[hdr[7:0]]
                                                         : 16'hA5A5;
        end
    end
    // Data leaves on falling clock; once released the line inverts
    always @(negedge ee_sck or posedge ee_cs_n) begin
        if (!ee_cs_n && bits >= 16 && bits < 32) ee_miso <= word[31 - bits];
        else ee_miso <= ~ee_miso;
    end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the port configuration loader
`timescale 1ns/100ps
module testbench;
    ////////////////////////////////////////
    localparam logic [15:0] SIG = 16'h1E87; // Arbitrary signature value
    localparam logic [2:0][15:0] SLOT_LD = {16'h53C2, 16'hA5B5, 16'hCA1D};
    localparam logic [2:0][15:0] TL_LD   = {16'h0370, 16'h01B3, 16'h0245};
    logic             sys_clk, nrst, avs_read, avs_write, ee_miso;
    logic [3:0]       avs_address, avs_byteenable;
    logic [31:0]      avs_writedata, avs_readdata, rd;
    logic             avs_waitrequest, ee_sck, ee_cs_n, ee_mosi, cfg_ready;
    logic [2:0]       slot_implemented, connector_clock, dsi_required;
    logic [2:0]       lpvc_vc1, port_disable, reset_pin_sel, clock_pm_cap;
    logic [2:0]       pcipm_l1_1_support, aspm_l1_1_support;
    logic [2:0]       l1_substates_support, vc_arbitration_mode;
    logic [2:0]       grant_fail_mode;
    logic [8:0]       logical_port_num;
    logic [20:0]      tc_vc0_map;
    logic [2:0][15:0] es, et;
    int               failures, num_checks, cycles;

    // Short serial clock keeps loads brief
    epcl_loader #(.SIGNATURE(SIG), .SCK_HALF(3)) epcl_loader_inst (.*);
    epcl_ee_model epcl_ee_model_inst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            results();
        end
    end
    ////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [15:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic [31:0] c(logic [2:0][15:0] w, int b);
        return {29'h0, w[2][b], w[1][b], w[0][b]};
    endfunction
    task automatic chk_fields(input logic [2:0][15:0] s, t);
        check("impl", 32'(slot_implemented), c(s, 0));
        check("clk", 32'(connector_clock), c(s, 1));
        check("dsi", 32'(dsi_required), c(s, 2));
        check("lpvc", 32'(lpvc_vc1), c(s, 3));
        check("pnum", 32'(logical_port_num),
              {23'h0, s[2][6:4], s[1][6:4], s[0][6:4]});
        check("tcm", 32'(tc_vc0_map),
              {11'h0, s[2][15:9], s[1][15:9], s[0][15:9]});
        check("dis", 32'(port_disable), c(t, 0));
        check("rsel", 32'(reset_pin_sel), c(t, 1));
        check("cpm", 32'(clock_pm_cap), c(t, 2));
        check("pm", 32'(pcipm_l1_1_support), c(t, 4));
        check("aspm", 32'(aspm_l1_1_support), c(t, 5));
        check("ss", 32'(l1_substates_support), c(t, 6));
        check("arb", 32'(vc_arbitration_mode), c(t, 8));
        check("gf", 32'(grant_fail_mode), c(t, 9));
    endtask
    ////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        epcl_ee_model_inst.mem[8'h00] = ~SIG;
        repeat (10) @(posedge sys_clk);
        check("wait_rdy", 32'({avs_waitrequest, cfg_ready}), 32'h2);
        chk_fields(epcl_pkg::SLOT_DEF, epcl_pkg::TL_DEF);
        nrst <= 1'b1;
        bus(1'b0, epcl_pkg::REG_STATUS, 16'h0, 4'hF);
        check("status", rd & 32'h3, 32'h1);
        chk_fields(epcl_pkg::SLOT_DEF, epcl_pkg::TL_DEF);
        $display("test no_memory done");
        epcl_ee_model_inst.mem[8'h00] = SIG;
        for (int p = 0; p < 3; p++) begin
            epcl_ee_model_inst.mem[8'h60 + 8'(2 * p)] = SLOT_LD[p];
            epcl_ee_model_inst.mem[8'h68 + 8'(2 * p)] = TL_LD[p];
        end
        bus(1'b1, epcl_pkg::REG_CTRL, 16'h0001, 4'hF);
        bus(1'b0, epcl_pkg::REG_STATUS, 16'h0, 4'hF);
        check("status", rd & 32'hF3, 32'h53);
        chk_fields(SLOT_LD, TL_LD);
        bus(1'b0, 4'h5, 16'h0, 4'hF);
        check("slot1_rd", rd, {16'h0, SLOT_LD[1] & 16'hFE7F});
        $display("test load done");
        es = SLOT_LD;
        et = TL_LD;
        bus(1'b1, 4'h5, ~SLOT_LD[1], 4'hF);
        bus(1'b1, 4'h6, ~SLOT_LD[2], 4'hF);
        bus(1'b1, 4'h4, 16'hFFFF, 4'h2);
        bus(1'b1, 4'h9, ~TL_LD[1], 4'hF);
        bus(1'b1, 4'hA, 16'h0377, 4'h1);
        bus(1'b1, 4'h3, 16'hFFFF, 4'hF);
        es[1] = es[1] ^ epcl_pkg::SW_WRITABLE;
        es[2] = es[2] ^ epcl_pkg::SW_WRITABLE;
        es[0] = es[0] | (16'hFF00 & epcl_pkg::SW_WRITABLE);
        et[1] = ~et[1];
        et[2] = {et[2][15:8], 8'h77};
        chk_fields(es, et);
        bus(1'b0, 4'hF, 16'h0, 4'hF);
        check("unmapped", rd, 32'h0);
        $display("test software done");
        nrst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk_fields(epcl_pkg::SLOT_DEF, epcl_pkg::TL_DEF);
        nrst <= 1'b1;
        bus(1'b0, epcl_pkg::REG_STATUS, 16'h0, 4'hF);
        check("status", rd & 32'hF3, 32'h53);
        chk_fields(SLOT_LD, TL_LD);
        $display("test reload done");
        results();
    end
endmodule
